// *** irq_pkg.sv ***
// Purpose: Shared constants and carrier types for the interrupt enable and status block.
// Assumes: An 8-bit parallel host register port with a one-cycle read and write strobe.
// Notes:   Offsets are the byte addresses of the host register map.
package irq_pkg;
	localparam logic [7:0] primary_enable_offset   = 8'h64;
	localparam logic [7:0] secondary_enable_offset = 8'h7d;
	localparam logic [7:0] secondary_peek_offset   = 8'h7e;
	localparam logic [7:0] secondary_cor_offset    = 8'h7f;
	localparam logic [7:0] primary_enable_reset    = 8'h00;
	localparam logic [7:0] secondary_enable_reset  = 8'h00;
	localparam logic [7:0] secondary_flags_reset   = 8'h00;
	localparam logic [7:0] secondary_valid_mask    = 8'h3d;
	localparam int         wake_bit                = 5;
	localparam int         link_bit                = 4;
	localparam int         jabber_bit              = 3;
	localparam int         neg_fail_bit            = 2;
	localparam int         neg_done_bit            = 0;
	localparam int         tx_done_bit             = 2;
	localparam int         rx_full_bit             = 1;
	localparam int         osc_ready_bit           = 4;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic network_wake;
		logic link_change;
		logic jabber;
		logic neg_failed;
		logic neg_done;
	} link_events_t;
endpackage

// *** sticky_flags.sv ***
// Purpose: Bank of sticky event flags with a clear strobe.
// Assumes: Events are one-cycle or level requests synchronous to clk.
// Notes:   A set in the same cycle as a clear wins.
`timescale 1ns/10ps
module sticky_flags
	import irq_pkg::*;
#(
	parameter int         WIDTH = 8,
	parameter logic [7:0] INIT  = 8'h00
)
(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic             clear,
	output logic      [WIDTH-1:0] flags
);
	logic [WIDTH-1:0] flags_reg;
	logic [WIDTH-1:0] flags_next;

	always_comb
	begin
		flags_next = (clear ? '0 : flags_reg) | set_in;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			flags_reg <= INIT[WIDTH-1:0];
		else
			flags_reg <= flags_next;
	end

	assign flags = flags_reg;
endmodule

// *** ethernet_irq_enable_status.sv ***
// Purpose: Interrupt enable and secondary status logic of the Ethernet controller.
// Assumes: Host strobes last one cycle; primary flags arrive from outside as levels.
// Notes:   Read data is registered and valid the cycle after the read strobe.
// Overview of operation
// - Clear-on-read view returns flags, then clears all but those set in the same cycle.
// - Peek view returns flags, leaves them untouched.
// - Network connect sets wake flag bit 5.
// - Any link status change sets bit 4.
// - Jabber detection sets bit 3.
// - Negotiation failure sets bit 2.
// - Negotiation completion sets bit 0.
// - Peek bit 1 always reads zero.
// - Bits 7 and 6 read zero, ignore writes.
// - Primary enable bit 2 gates transmit done.
// - Primary enable bit 1 gates receive full.
// - Primary enable bit 4 gates oscillator ready.
// - Secondary enable bit 0 gates negotiation done.
// - Receive empty flag sticks until cleared.
// - Self init flag sticks until cleared.
`timescale 1ns/10ps
module ethernet_irq_enable_status
	import irq_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire host_req_t    host_req,
	output logic       [7:0]  host_rdata,
	input  wire link_events_t link_events,
	input  wire logic  [7:0]  primary_flags,
	input  wire logic         rx_fifo_empty_event,
	input  wire logic         self_init_done_event,
	input  wire logic         primary_flags_clear,
	output logic              rx_fifo_empty_flag,
	output logic              self_init_done_flag,
	output logic       [7:0]  primary_irq_enable,
	output logic              irq_request
);
	logic [7:0] primary_enable_reg;
	logic [7:0] primary_enable_next;
	logic [7:0] secondary_enable_reg;
	logic [7:0] secondary_enable_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] sec_set;
	logic [7:0] sec_flags;
	logic [1:0] prim_sticky;
	logic       cor_read;
	logic [7:0] prim_view;
	logic       irq_next;
	logic       irq_reg;

	function automatic logic hit(input host_req_t r, input logic [7:0] off);
		return r.addr == off;
	endfunction

	assign cor_read = host_req.rd && hit(host_req, secondary_cor_offset);

	always_comb
	begin
		sec_set = 8'h00;
		sec_set[wake_bit]     = link_events.network_wake;
		sec_set[link_bit]     = link_events.link_change;
		sec_set[jabber_bit]   = link_events.jabber;
		sec_set[neg_fail_bit] = link_events.neg_failed;
		sec_set[neg_done_bit] = link_events.neg_done;
	end

	sticky_flags #(
		.WIDTH (8),
		.INIT  (secondary_flags_reset)
	) u_secondary (
		.clk    (clk),
		.resetn (resetn),
		.set_in (sec_set),
		.clear  (cor_read),
		.flags  (sec_flags)
	);

	sticky_flags #(
		.WIDTH (2),
		.INIT  (8'h00)
	) u_primary_sticky (
		.clk    (clk),
		.resetn (resetn),
		.set_in ({self_init_done_event, rx_fifo_empty_event}),
		.clear  (primary_flags_clear),
		.flags  (prim_sticky)
	);

	assign rx_fifo_empty_flag  = prim_sticky[0];
	assign self_init_done_flag = prim_sticky[1];

	always_comb
	begin
		prim_view    = primary_flags;
		prim_view[6] = prim_sticky[0];
		prim_view[5] = prim_sticky[1];
	end

	always_comb
	begin
		primary_enable_next   = primary_enable_reg;
		secondary_enable_next = secondary_enable_reg;
		rdata_next            = rdata_reg;
		if (host_req.wr && hit(host_req, primary_enable_offset))
			primary_enable_next = host_req.wdata;
		if (host_req.wr && hit(host_req, secondary_enable_offset))
			secondary_enable_next = host_req.wdata & secondary_valid_mask;
		if (host_req.rd)
		begin
			if (hit(host_req, primary_enable_offset))
				rdata_next = primary_enable_reg;
			else if (hit(host_req, secondary_enable_offset))
				rdata_next = secondary_enable_reg;
			else if (hit(host_req, secondary_peek_offset) || cor_read)
				rdata_next = sec_flags & secondary_valid_mask;
			else
				rdata_next = 8'h00;
		end
		irq_next = |(prim_view & primary_enable_reg)
			| |(sec_flags & secondary_enable_reg & secondary_valid_mask);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			primary_enable_reg   <= primary_enable_reset;
			secondary_enable_reg <= secondary_enable_reset;
			rdata_reg            <= 8'h00;
			irq_reg              <= 1'b0;
		end
		else
		begin
			primary_enable_reg   <= primary_enable_next;
			secondary_enable_reg <= secondary_enable_next;
			rdata_reg            <= rdata_next;
			irq_reg              <= irq_next;
		end
	end

	assign host_rdata         = rdata_reg;
	assign primary_irq_enable = primary_enable_reg;
	assign irq_request        = irq_reg;

	property p_cor_clears;
		@(posedge clk) disable iff (!resetn)
		cor_read && !(|sec_set) |=> sec_flags == 8'h00;
	endproperty
	a_cor_clears: assert property (p_cor_clears) else $error("Clear-on-read left flags set.");

	property p_peek_keeps;
		@(posedge clk) disable iff (!resetn)
		host_req.rd && hit(host_req, secondary_peek_offset) |=> sec_flags == ($past(sec_flags) | $past(sec_set));
	endproperty
	a_peek_keeps: assert property (p_peek_keeps) else $error("Peek altered flags.");

	property p_peek_data;
		@(posedge clk) disable iff (!resetn)
		host_req.rd && hit(host_req, secondary_peek_offset) |=> host_rdata == ($past(sec_flags) & secondary_valid_mask);
	endproperty
	a_peek_data: assert property (p_peek_data) else $error("Peek returned wrong data.");

	property p_wake_set;
		@(posedge clk) disable iff (!resetn)
		link_events.network_wake |=> sec_flags[wake_bit];
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("Wake flag not set.");

	property p_link_set;
		@(posedge clk) disable iff (!resetn)
		link_events.link_change |=> sec_flags[link_bit];
	endproperty
	a_link_set: assert property (p_link_set) else $error("Link change flag not set.");

	property p_jabber_set;
		@(posedge clk) disable iff (!resetn)
		link_events.jabber |=> sec_flags[jabber_bit];
	endproperty
	a_jabber_set: assert property (p_jabber_set) else $error("Jabber flag not set.");

	property p_neg_fail_hold;
		@(posedge clk) disable iff (!resetn)
		sec_flags[neg_fail_bit] && !cor_read |=> sec_flags[neg_fail_bit];
	endproperty
	a_neg_fail_hold: assert property (p_neg_fail_hold) else $error("Negotiation failed flag dropped.");

	property p_neg_done_set;
		@(posedge clk) disable iff (!resetn)
		link_events.neg_done |=> sec_flags[neg_done_bit];
	endproperty
	a_neg_done_set: assert property (p_neg_done_set) else $error("Negotiation done flag not set.");

	sequence s_status_read;
		host_req.rd && (hit(host_req, secondary_peek_offset) || hit(host_req, secondary_cor_offset));
	endsequence

	sequence s_sec_read;
		host_req.rd && (hit(host_req, secondary_peek_offset) || cor_read || hit(host_req, secondary_enable_offset));
	endsequence

	property p_reserved_zero;
		@(posedge clk) disable iff (!resetn)
		s_status_read |=> host_rdata[1] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit read as one.");

	property p_unused_enable;
		@(posedge clk) disable iff (!resetn)
		secondary_enable_reg[7:6] == 2'b00;
	endproperty
	a_unused_enable: assert property (p_unused_enable) else $error("Unused enable bits set.");

	property p_tx_gate;
		@(posedge clk) disable iff (!resetn)
		primary_flags[tx_done_bit] && primary_enable_reg[tx_done_bit] |=> irq_request;
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("Transmit done did not interrupt.");

	property p_rx_full_gate;
		@(posedge clk) disable iff (!resetn)
		primary_flags[rx_full_bit] && primary_enable_reg[rx_full_bit] |=> irq_request;
	endproperty
	a_rx_full_gate: assert property (p_rx_full_gate) else $error("Receive full did not interrupt.");

	property p_osc_gate;
		@(posedge clk) disable iff (!resetn)
		primary_flags[osc_ready_bit] && primary_enable_reg[osc_ready_bit] |=> irq_request;
	endproperty
	a_osc_gate: assert property (p_osc_gate) else $error("Oscillator ready did not interrupt.");

	property p_idle_low;
		@(posedge clk) disable iff (!resetn)
		!(|(prim_view & primary_enable_reg)) && !(|(sec_flags & secondary_enable_reg)) |=> !irq_request;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("Interrupt request with nothing enabled.");

	property p_sec_gate;
		@(posedge clk) disable iff (!resetn)
		sec_flags[neg_done_bit] && secondary_enable_reg[neg_done_bit] |=> irq_request;
	endproperty
	a_sec_gate: assert property (p_sec_gate) else $error("Secondary flag did not interrupt.");

	property p_empty_hold;
		@(posedge clk) disable iff (!resetn)
		rx_fifo_empty_flag && !primary_flags_clear |=> rx_fifo_empty_flag;
	endproperty
	a_empty_hold: assert property (p_empty_hold) else $error("Receive empty flag dropped.");

	property p_unused_read;
		@(posedge clk) disable iff (!resetn)
		s_sec_read |=> host_rdata[7:6] == 2'b00;
	endproperty
	a_unused_read: assert property (p_unused_read) else $error("Unused bits read as one.");

	property p_cor_data;
		@(posedge clk) disable iff (!resetn)
		cor_read |=> host_rdata == ($past(sec_flags) & secondary_valid_mask);
	endproperty
	a_cor_data: assert property (p_cor_data) else $error("Clear-on-read returned wrong data.");

	property p_wake_hold;
		@(posedge clk) disable iff (!resetn)
		sec_flags[wake_bit] && !cor_read |=> sec_flags[wake_bit];
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("Wake flag dropped.");

	property p_link_hold;
		@(posedge clk) disable iff (!resetn)
		sec_flags[link_bit] && !cor_read |=> sec_flags[link_bit];
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("Link change flag dropped.");

	property p_jabber_set_wins;
		@(posedge clk) disable iff (!resetn)
		cor_read && link_events.jabber |=> sec_flags[jabber_bit];
	endproperty
	a_jabber_set_wins: assert property (p_jabber_set_wins) else $error("Jabber lost to a clearing read.");

	property p_neg_fail_set;
		@(posedge clk) disable iff (!resetn)
		link_events.neg_failed |=> sec_flags[neg_fail_bit];
	endproperty
	a_neg_fail_set: assert property (p_neg_fail_set) else $error("Negotiation failed flag not set.");

	property p_neg_done_hold;
		@(posedge clk) disable iff (!resetn)
		sec_flags[neg_done_bit] && !cor_read |=> sec_flags[neg_done_bit];
	endproperty
	a_neg_done_hold: assert property (p_neg_done_hold) else $error("Negotiation done flag dropped.");

	property p_rx_empty_set;
		@(posedge clk) disable iff (!resetn)
		rx_fifo_empty_event |=> rx_fifo_empty_flag;
	endproperty
	a_rx_empty_set: assert property (p_rx_empty_set) else $error("Receive empty flag not set.");

	property p_self_hold;
		@(posedge clk) disable iff (!resetn)
		self_init_done_flag && !primary_flags_clear |=> self_init_done_flag;
	endproperty
	a_self_hold: assert property (p_self_hold) else $error("Self init flag dropped.");

	property p_sec_any_gate;
		@(posedge clk) disable iff (!resetn)
		|(sec_flags & secondary_enable_reg) |=> irq_request;
	endproperty
	a_sec_any_gate: assert property (p_sec_any_gate) else $error("Enabled secondary flag did not interrupt.");
endmodule

// *** host_model.sv ***
// Purpose: Host processor model that drives the parallel register port.
// Assumes: One-cycle strobes; read data is valid one cycle after the read strobe.
// Notes:   While idle, address and data show the inverse of their last values.
`timescale 1ns/10ps
module host_model
	import irq_pkg::*;
(
	input  wire logic      clk,
	input  wire logic [7:0] rdata,
	output host_req_t      req
);
	initial req = '0;

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1;
		req = '{~w, w, a, d};
		@(posedge clk);
		#1;
		q = rdata;
		req = '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the interrupt enable and status block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   The interrupt request output lags its cause by one cycle.
`timescale 1ns/10ps
module testbench
	import irq_pkg::*;
;
	logic         clk = 1'b0;
	logic         resetn = 1'b0;
	host_req_t    req;
	logic  [7:0]  rdata;
	logic  [7:0]  pflags = 8'h00;
	logic  [7:0]  pen;
	link_events_t ev = '0;
	logic         rxe_ev = 1'b0;
	logic         self_ev = 1'b0;
	logic         pclr = 1'b0;
	logic         rxe_flag;
	logic         self_flag;
	logic         irq;
	int           fail_count = 0;
	int           checked = 0;
	logic  [31:0] seed = 32'd15;

	always #50 clk = ~clk;

	ethernet_irq_enable_status dut (.clk(clk), .resetn(resetn), .host_req(req), .host_rdata(rdata),
		.link_events(ev), .primary_flags(pflags), .rx_fifo_empty_event(rxe_ev),
		.self_init_done_event(self_ev), .primary_flags_clear(pclr), .rx_fifo_empty_flag(rxe_flag),
		.self_init_done_flag(self_flag), .primary_irq_enable(pen), .irq_request(irq));
	host_model host (.clk(clk), .rdata(rdata), .req(req));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic exp_irq(logic [7:0] pf, logic [7:0] en, logic rxe, logic slf);
		logic [7:0] p;
		p = pf;
		p[6] = rxe;
		p[5] = slf;
		return |(p & en);
	endfunction

	task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		logic [7:0] q;
		host.xfer(1'b0, a, 8'h00, q);
		check8(n, e, q);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer(1'b1, a, d, q);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic final_report();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#2000000;
		fail_count++;
		final_report();
	end

	initial
	begin
		logic [31:0] r;
		logic [7:0]  m;
		logic        rm;
		logic        sm;
		int          pb[3];
		pb = '{tx_done_bit, rx_full_bit, osc_ready_bit};
		step(3);
		resetn = 1'b1;
		rd(primary_enable_offset, primary_enable_reset, "pen_rst");
		rd(secondary_enable_offset, secondary_enable_reset, "sen_rst");
		rd(secondary_peek_offset, secondary_flags_reset, "peek_rst");
		rd(secondary_cor_offset, secondary_flags_reset, "cor_rst");
		rd(8'h10, 8'h00, "unmapped");
		check8("irq_rst", 8'h00, {7'h00, irq});
		r = xs();
		wr(primary_enable_offset, r[7:0]);
		rd(primary_enable_offset, r[7:0], "pen_rw");
		check8("pen_port", r[7:0], pen);
		wr(secondary_enable_offset, 8'hff);
		rd(secondary_enable_offset, secondary_valid_mask, "sen_mask");
		wr(secondary_peek_offset, 8'hff);
		rd(secondary_peek_offset, 8'h00, "peek_ro");
		$display("test registers done");
		for (int i = 0; i < 5; i++)
		begin
			m = (i == 4) ? 8'h01 : 8'h20 >> i;
			wr(secondary_enable_offset, ~m & secondary_valid_mask);
			ev = link_events_t'(5'h10 >> i);
			step(1);
			ev = '0;
			step(1);
			check8("irq_masked", 8'h00, {7'h00, irq});
			wr(secondary_enable_offset, m);
			step(1);
			check8("irq_sec", 8'h01, {7'h00, irq});
			rd(secondary_peek_offset, m, "peek_set");
			rd(secondary_peek_offset, m, "peek_keep");
			rd(secondary_cor_offset, m, "cor_read");
			rd(secondary_peek_offset, 8'h00, "cor_clr");
			check8("irq_ack", 8'h00, {7'h00, irq});
		end
		ev = '1;
		rd(secondary_cor_offset, secondary_valid_mask, "cor_all");
		ev = '0;
		rd(secondary_peek_offset, secondary_valid_mask, "cor_set_wins");
		rd(secondary_cor_offset, secondary_valid_mask, "cor_all2");
		rd(secondary_peek_offset, 8'h00, "cor_clr_all");
		$display("test secondary done");
		for (int i = 0; i < 3; i++)
		begin
			pflags = 8'h01 << pb[i];
			wr(primary_enable_offset, pflags);
			step(1);
			check8("irq_pri_on", 8'h01, {7'h00, irq});
			wr(primary_enable_offset, ~pflags);
			step(1);
			check8("irq_pri_off", 8'h00, {7'h00, irq});
		end
		$display("test primary done");
		rxe_ev = 1'b1;
		self_ev = 1'b1;
		step(1);
		rxe_ev = 1'b0;
		self_ev = 1'b0;
		step(3);
		check8("sticky", 8'h03, {6'h00, rxe_flag, self_flag});
		pclr = 1'b1;
		step(1);
		pclr = 1'b0;
		step(1);
		check8("sticky_clr", 8'h00, {6'h00, rxe_flag, self_flag});
		$display("test sticky done");
		rm = 1'b0;
		sm = 1'b0;
		for (int k = 0; k < 24; k++)
		begin
			r = xs();
			pflags = r[7:0];
			rxe_ev = r[8];
			self_ev = r[9];
			rm = rm | r[8];
			sm = sm | r[9];
			wr(primary_enable_offset, r[23:16]);
			rxe_ev = 1'b0;
			self_ev = 1'b0;
			step(1);
			check8("irq_rand", {7'h00, exp_irq(r[7:0], r[23:16], rm, sm)}, {7'h00, irq});
		end
		$display("test random done");
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		rd(primary_enable_offset, primary_enable_reset, "pen_rst2");
		check8("sticky_rst", 8'h00, {6'h00, rxe_flag, self_flag});
		check8("irq_rst2", 8'h00, {7'h00, irq});
		$display("test reset done");
		final_report();
	end
endmodule
